// [core/sleep_wake_control.sv]
/*
 * Sleep entry and wake control with watchdog, interrupt flag registers,
 * fault flag register and a classic Wishbone register slave.
 * Assumes the core gives one-cycle pulses on sys_clk for sleep, clear
 * watchdog and instruction retire; analog and pin inputs are asynchronous.
 */
module sleep_wake_control
    import sleep_wake_pkg::*;
#(
    parameter int WDT_CYCLES = WDT_BASE_CYCLES, // base watchdog period
    parameter int WDT_W      = 24               // watchdog counter width
) (
    input  wire logic        sys_clk,            // system clock
    input  wire logic        rst,                // power-on reset
    input  wire logic        wb_cyc_i,           // bus cycle
    input  wire logic        wb_stb_i,           // bus strobe
    input  wire logic        wb_we_i,            // write enable
    input  wire logic [7:0]  wb_adr_i,           // byte address
    input  wire logic [3:0]  wb_sel_i,           // byte lanes
    input  wire logic [31:0] wb_dat_i,           // write data
    output logic      [31:0] wb_dat_o,           // read data
    output logic             wb_ack_o,           // acknowledge
    input  wire logic        sleep_exec,         // sleep instruction pulse
    input  wire logic        clrwdt_exec,        // clear-watchdog pulse
    input  wire logic        instr_retire,       // instruction done pulse
    input  wire logic        watchdog_enable,    // configuration enable
    input  wire logic        ext_reset_enable,   // reset pin enable
    input  wire logic        external_reset_pin_n, // reset pin, low active
    input  wire logic        brownout_reset,     // supply monitor reset
    input  wire logic        ext_int_pin,        // external interrupt pin
    input  wire logic        vin_high_level,     // input overvoltage
    input  wire logic        vin_low_level,      // input undervoltage
    input  wire logic        out_undervolt,      // output undervoltage
    input  wire logic        overtemp,           // overtemperature
    input  wire logic        out_overcurrent,    // output overcurrent
    input  wire logic        out_overvolt,       // output overvoltage
    input  wire logic [7:0]  pin_change_a,       // change pins, port a
    input  wire logic [7:0]  pin_change_b,       // change pins, port b
    input  wire logic [7:0]  periph_events_a,    // peripheral set pulses
    output logic             cpu_clk_en,         // core clock gate
    output logic             analog_supply_on,   // analog rail enable
    output logic             port_hold,          // freeze pin drivers
    output logic             prefetch_req,       // fetch next address
    output logic             core_reset,         // full device reset
    output logic             irq_req,            // interrupt to core
    output logic             asleep              // power-down state
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] lvl;
        ctl_state_e        state;
        logic [7:0]        irq_control;
        logic [7:0]        option_settings;
        logic [7:0]        pie_a;
        logic [7:0]        pie_b;
        logic [7:0]        pir_a;
        logic [7:0]        fault;
        logic [7:0]        ioc_a;
        logic [7:0]        ioc_b;
        logic [7:0]        status;
        logic [7:0]        lockout_config;
        logic [WDT_W-1:0]  wdt_cnt;
        logic [7:0]        wdt_pre;
        logic [31:0]       dat;
        logic              ack;
        logic              clk_en;
        logic              ana_on;
        logic              hold;
        logic              prefetch;
        logic              creset;
        logic              irq;
    } ctl_s;

    localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
    localparam logic [WDT_W-1:0] WDT_ONE  = WDT_W'(1);
    // idle pin levels: only the low-active reset pin rests high
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << SY_EXT_RST;

    ctl_s st_r;
    ctl_s st_nxt;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;
    logic [7:0]        rd_val;
    logic [7:0]        wd;
    logic [7:0]        pre_last;
    logic              wr;
    logic              wake_src;
    logic              periph_pend;
    logic              ext_rst_evt;
    logic              bor_evt;
    logic              wdt_run;
    logic              wdt_tick;
    logic              wdt_out;
    logic              wdt_clr;

    assign pins = {pin_change_b, pin_change_a, out_overvolt, out_overcurrent,
                   overtemp, out_undervolt, vin_low_level, vin_high_level,
                   ext_int_pin, brownout_reset, external_reset_pin_n};

    always_comb begin
        case (wb_adr_i)
            ADR_IRQ_CONTROL: rd_val = st_r.irq_control;
            ADR_OPTION:      rd_val = st_r.option_settings;
            ADR_PIE_A:       rd_val = st_r.pie_a;
            ADR_PIE_B:       rd_val = st_r.pie_b & FAULT_IMPL_MASK;
            ADR_PIR_A:       rd_val = st_r.pir_a;
            ADR_FAULT:       rd_val = st_r.fault & FAULT_IMPL_MASK;
            ADR_IOC_A:       rd_val = st_r.ioc_a;
            ADR_IOC_B:       rd_val = st_r.ioc_b;
            ADR_STATUS:      rd_val = st_r.status;
            ADR_LOCKOUT_CFG: rd_val = st_r.lockout_config;
            default:         rd_val = RST_ZERO;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // a change counts once stages two and three agree
        st_nxt.s1  = pins;
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
        rise = st_nxt.lvl & ~st_r.lvl;
        fall = st_r.lvl & ~st_nxt.lvl;
        ext_rst_evt = ext_reset_enable & ~st_r.lvl[SY_EXT_RST];
        // brown-out is not armed in sleep; the pin reset is, whenever ext_reset_enable is set
        bor_evt = st_r.lvl[SY_BOR] & (st_r.state != ST_SLEEP);

        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
            st_nxt.dat = {24'h000000, rd_val};
        end
        wr = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack & wb_sel_i[0];
        wd = wb_dat_i[7:0];

        if (wr) begin
            case (wb_adr_i)
                ADR_IRQ_CONTROL: st_nxt.irq_control = wd;
                ADR_OPTION:      st_nxt.option_settings = wd;
                ADR_PIE_A:       st_nxt.pie_a = wd;
                ADR_PIE_B:       st_nxt.pie_b = wd & FAULT_IMPL_MASK;
                ADR_PIR_A:       st_nxt.pir_a = wd;
                // flags only fall on a written zero or a device reset
                ADR_FAULT:       st_nxt.fault = st_r.fault & wd;
                ADR_IOC_A:       st_nxt.ioc_a = wd;
                ADR_IOC_B:       st_nxt.ioc_b = wd;
                ADR_STATUS: begin
                    st_nxt.status = wd;
                    st_nxt.status[ST_TO] = st_r.status[ST_TO];
                    st_nxt.status[ST_PD] = st_r.status[ST_PD];
                end
                ADR_LOCKOUT_CFG: st_nxt.lockout_config = wd & CFG_IMPL_MASK;
                default: begin
                end
            endcase
        end

        // hardware sets after the write, so a set beats a clear
        st_nxt.pir_a = st_nxt.pir_a | periph_events_a;
        st_nxt.fault[FL_UV] = st_nxt.fault[FL_UV] | rise[SY_UV];
        st_nxt.fault[FL_OT] = st_nxt.fault[FL_OT] | rise[SY_OT];
        st_nxt.fault[FL_OC] = st_nxt.fault[FL_OC] | rise[SY_OC];
        st_nxt.fault[FL_OV] = st_nxt.fault[FL_OV] | rise[SY_OV];
        st_nxt.fault[FL_VHI] = st_nxt.fault[FL_VHI]
            | (st_r.lockout_config[CF_VHI_RISE] & rise[SY_VHI])
            | (st_r.lockout_config[CF_VHI_FALL] & fall[SY_VHI]);
        st_nxt.fault[FL_VLO] = st_nxt.fault[FL_VLO]
            | (st_r.lockout_config[CF_VLO_RISE] & rise[SY_VLO])
            | (st_r.lockout_config[CF_VLO_FALL] & fall[SY_VLO]);
        st_nxt.irq_control[IC_INTF] = st_nxt.irq_control[IC_INTF]
            | (st_r.option_settings[OPT_INTEDG] ? rise[SY_INT]
                                                 : fall[SY_INT]);
        st_nxt.irq_control[IC_IOCF] = st_nxt.irq_control[IC_IOCF]
            | (|((rise[SY_PCA +: 8] | fall[SY_PCA +: 8]) & st_r.ioc_a))
            | (|((rise[SY_PCB +: 8] | fall[SY_PCB +: 8]) & st_r.ioc_b));

        // besides the watchdog, only the two pin sources wake; global enable plays no part
        wake_src = (st_r.irq_control[IC_INTE] & st_r.irq_control[IC_INTF])
                 | (st_r.irq_control[IC_IOCE]
                    & st_r.irq_control[IC_IOCF]);
        periph_pend = st_r.irq_control[IC_PERIPH_IRQ_MASTER_ENABLE]
            & (|(st_r.pie_a & st_r.pir_a)
               | |(st_r.pie_b & st_r.fault));

        // watchdog with optional power-of-two postscaler
        wdt_run = watchdog_enable & ((st_r.state != ST_SLEEP)
                  | st_r.lockout_config[CF_WDT_SLP]);
        pre_last = (8'h01 << st_r.option_settings[OPT_PS_MSB:0]) - 8'h01;
        wdt_tick = wdt_run & (st_r.wdt_cnt == WDT_LAST);
        wdt_out = wdt_tick & (~st_r.option_settings[OPT_PSA]
                  | (st_r.wdt_pre == pre_last));
        wdt_clr = clrwdt_exec | ~watchdog_enable;
        if (wdt_run) begin
            st_nxt.wdt_cnt = wdt_tick ? '0 : st_r.wdt_cnt + WDT_ONE;
            if (wdt_tick) begin
                st_nxt.wdt_pre = wdt_out ? 8'h00 : st_r.wdt_pre + 8'h01;
            end
        end

        st_nxt.prefetch = 1'b0;
        st_nxt.creset = 1'b0;
        case (st_r.state)
            ST_RUN, ST_STEP: begin
                if (st_r.state == ST_STEP && instr_retire) begin
                    st_nxt.state = ST_RUN;
                end
                if (sleep_exec) begin
                    st_nxt.prefetch = 1'b1;
                    if (!wake_src) begin
                        st_nxt.state = ST_SLEEP;
                        wdt_clr = 1'b1;
                        st_nxt.status[ST_PD] = 1'b0;
                        st_nxt.status[ST_TO] = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (wdt_out) begin
                    st_nxt.state = ST_RUN;
                    st_nxt.status[ST_TO] = 1'b0;
                    wdt_clr = 1'b1;
                end else if (wake_src) begin
                    st_nxt.state = ST_STEP;
                    wdt_clr = 1'b1;
                end
            end
            default: st_nxt.state = ST_RUN;
        endcase
        if (wdt_clr) begin
            st_nxt.wdt_cnt = '0;
            st_nxt.wdt_pre = 8'h00;
        end

        if (ext_rst_evt || bor_evt
            || (wdt_out && st_r.state != ST_SLEEP)) begin
            st_nxt.state           = ST_RUN;
            st_nxt.irq_control     = RST_IRQ_CONTROL;
            st_nxt.option_settings = RST_OPTION;
            st_nxt.pie_a           = RST_ZERO;
            st_nxt.pie_b           = RST_ZERO;
            st_nxt.pir_a           = RST_ZERO;
            st_nxt.fault           = RST_ZERO;
            st_nxt.ioc_a           = RST_ZERO;
            st_nxt.ioc_b           = RST_ZERO;
            st_nxt.lockout_config  = RST_CFG;
            st_nxt.wdt_cnt         = '0;
            st_nxt.wdt_pre         = 8'h00;
            st_nxt.creset          = 1'b1;
            // pin reset keeps the flags so firmware can see the cause
            if (!ext_rst_evt) begin
                st_nxt.status = RST_STATUS;
                st_nxt.status[ST_TO] = ~(wdt_out & ~bor_evt);
            end
        end

        st_nxt.clk_en = (st_nxt.state != ST_SLEEP);
        st_nxt.hold   = (st_nxt.state == ST_SLEEP);
        st_nxt.ana_on = ~((st_nxt.state == ST_SLEEP)
                          & st_nxt.lockout_config[CF_ASE]);
        // core pushes only the return address on entry
        st_nxt.irq = (st_nxt.state == ST_RUN)
            & st_nxt.irq_control[IC_GIE]
            & ((st_nxt.irq_control[IC_T0IE] & st_nxt.irq_control[IC_T0IF])
               | wake_src | periph_pend);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r                 <= '0;
            // idle levels, so no false edge follows reset
            st_r.s1              <= SYNC_IDLE;
            st_r.s2              <= SYNC_IDLE;
            st_r.s3              <= SYNC_IDLE;
            st_r.lvl             <= SYNC_IDLE;
            st_r.state           <= ST_RUN;
            st_r.irq_control     <= RST_IRQ_CONTROL;
            st_r.option_settings <= RST_OPTION;
            st_r.status          <= RST_STATUS;
            st_r.lockout_config  <= RST_CFG;
            st_r.clk_en          <= 1'b1;
            st_r.ana_on          <= 1'b1;
            st_r.creset          <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o         = st_r.dat;
    assign wb_ack_o         = st_r.ack;
    assign cpu_clk_en       = st_r.clk_en;
    assign analog_supply_on = st_r.ana_on;
    assign port_hold        = st_r.hold;
    assign prefetch_req     = st_r.prefetch;
    assign core_reset       = st_r.creset;
    assign irq_req          = st_r.irq;
    assign asleep           = st_r.hold;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_sleep_entry_flags: assert property (
        sleep_exec && st_r.state == ST_RUN && !wake_src && !ext_rst_evt
        && !bor_evt && !wdt_out |=> st_r.state == ST_SLEEP
        && !st_r.status[ST_PD] && st_r.status[ST_TO] && st_r.wdt_cnt == '0)
        else $error("sleep entry did not update status");
    a_sleep_nop_keeps: assert property (
        sleep_exec && st_r.state == ST_RUN && wake_src && !ext_rst_evt
        && !bor_evt && !wdt_out |=> st_r.state == ST_RUN
        && st_r.status[ST_TO:ST_PD] == $past(st_r.status[ST_TO:ST_PD]))
        else $error("pending irq did not turn sleep into nop");
    a_clock_gated: assert property (
        st_r.state == ST_SLEEP |-> !cpu_clk_en && port_hold)
        else $error("core clock running while asleep");
    a_analog_rail_off: assert property (
        st_r.state == ST_SLEEP && st_r.lockout_config[CF_ASE]
        |-> !analog_supply_on)
        else $error("analog rail on in sleep");
    a_irq_wake_step: assert property (
        st_r.state == ST_SLEEP && wake_src && !wdt_out && !ext_rst_evt
        |=> st_r.state == ST_STEP && st_r.wdt_cnt == '0)
        else $error("enabled irq did not wake");
    a_step_blocks_irq: assert property (
        st_r.state == ST_STEP |-> !irq_req)
        else $error("irq taken before next instruction");
    a_fault_zero_bits: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == ADR_FAULT
        && $past(wb_adr_i) == ADR_FAULT |-> wb_dat_o[3:2] == 2'b00)
        else $error("unimplemented fault bits read nonzero");
    a_fault_sticky: assert property (
        st_r.fault[FL_OT] && !(wr && wb_adr_i == ADR_FAULT) && !ext_rst_evt
        && !bor_evt && !wdt_out |=> st_r.fault[FL_OT])
        else $error("fault flag cleared by itself");
    a_overtemp_sets: assert property (
        rise[SY_OT] && !ext_rst_evt && !bor_evt && !wdt_out
        |=> st_r.fault[FL_OT])
        else $error("overtemperature edge lost");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_periph_gate: assert property (
        irq_req && !$past(st_r.irq_control[IC_PERIPH_IRQ_MASTER_ENABLE]) |->
        ((st_r.irq_control[IC_T0IE] & st_r.irq_control[IC_T0IF])
         | $past(wake_src)))
        else $error("peripheral irq without master enable");
    a_prefetch_pulse: assert property (
        sleep_exec && st_r.state != ST_SLEEP && !ext_rst_evt && !bor_evt
        && !wdt_out |=> prefetch_req)
        else $error("no prefetch on sleep instruction");
    a_wdt_wake_resume: assert property (
        st_r.state == ST_SLEEP && wdt_out && !ext_rst_evt
        |=> st_r.state == ST_RUN && !core_reset && st_r.wdt_cnt == '0
        && !st_r.status[ST_TO])
        else $error("watchdog wake did not resume cleanly");
    a_brownout_masked: assert property (
        st_r.state == ST_SLEEP && st_r.lvl[SY_BOR] && !ext_rst_evt
        && !wdt_out && !wake_src |=> st_r.state == ST_SLEEP && !core_reset)
        else $error("brown-out acted while asleep");
    a_pin_reset_full: assert property (
        ext_rst_evt |=> core_reset && st_r.state == ST_RUN)
        else $error("reset pin did not reset the device");
    a_sleep_only_instr: assert property (
        st_r.state != ST_SLEEP && !sleep_exec |=> st_r.state != ST_SLEEP)
        else $error("sleep entered without instruction");
    a_awake_outputs: assert property (
        st_r.state != ST_SLEEP
        |-> cpu_clk_en && !port_hold && analog_supply_on)
        else $error("awake outputs not in run levels");
endmodule : sleep_wake_control

// [include/sleep_wake_pkg.sv]
/*
 * Constants for the sleep and wake controller: register offsets, bit
 * positions, reset values, watchdog timing and the controller states.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus with
 * byte addresses; every register is 8 bits wide in the low byte lane.
 */
package sleep_wake_pkg;
    localparam logic [7:0] ADR_IRQ_CONTROL  = 8'h00;
    localparam logic [7:0] ADR_OPTION       = 8'h04;
    localparam logic [7:0] ADR_PIE_A        = 8'h08;
    localparam logic [7:0] ADR_PIE_B        = 8'h0c;
    localparam logic [7:0] ADR_PIR_A        = 8'h10;
    localparam logic [7:0] ADR_FAULT        = 8'h14;
    localparam logic [7:0] ADR_IOC_A        = 8'h18;
    localparam logic [7:0] ADR_IOC_B        = 8'h1c;
    localparam logic [7:0] ADR_STATUS       = 8'h20;
    localparam logic [7:0] ADR_LOCKOUT_CFG  = 8'h24;

    // irq_control bits
    localparam int IC_GIE  = 7;
    localparam int IC_PERIPH_IRQ_MASTER_ENABLE = 6;
    localparam int IC_T0IE = 5;
    localparam int IC_INTE = 4;
    localparam int IC_IOCE = 3;
    localparam int IC_T0IF = 2;
    localparam int IC_INTF = 1;
    localparam int IC_IOCF = 0;
    // option_settings bits
    localparam int OPT_INTEDG = 6;
    localparam int OPT_PSA    = 3;
    localparam int OPT_PS_MSB = 2;
    // core_status bits
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    // fault_irq_flags bits
    localparam int FL_UV   = 7;
    localparam int FL_OT   = 6;
    localparam int FL_OC   = 5;
    localparam int FL_OV   = 4;
    localparam int FL_VHI  = 1;
    localparam int FL_VLO  = 0;
    localparam logic [7:0] FAULT_IMPL_MASK = 8'hf3;
    // lockout_config bits
    localparam int CF_VLO_RISE = 0;
    localparam int CF_VLO_FALL = 1;
    localparam int CF_VHI_RISE = 2;
    localparam int CF_VHI_FALL = 3;
    localparam int CF_ASE      = 4;
    localparam int CF_WDT_SLP  = 5;
    localparam logic [7:0] CFG_IMPL_MASK = 8'h3f;

    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_OPTION      = 8'hff;
    localparam logic [7:0] RST_STATUS      = 8'h18;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_CFG         = 8'h10;

    // watchdog base period
    localparam int WDT_PERIOD_US = 18;
    localparam int CLK_MHZ       = 50;
    localparam int WDT_BASE_CYCLES = WDT_PERIOD_US * CLK_MHZ;

    // positions in the synchronised pin vector
    localparam int SY_EXT_RST = 0;
    localparam int SY_BOR     = 1;
    localparam int SY_INT     = 2;
    localparam int SY_VHI     = 3;
    localparam int SY_VLO     = 4;
    localparam int SY_UV      = 5;
    localparam int SY_OT      = 6;
    localparam int SY_OC      = 7;
    localparam int SY_OV      = 8;
    localparam int SY_PCA     = 9;
    localparam int SY_PCB     = 17;
    localparam int SYNC_W     = 25;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STEP  = 2'b10
    } ctl_state_e;
endpackage : sleep_wake_pkg

// [tb/core_model.sv]
/* Core model: retires instructions and clears the watchdog while clocked.
   Assumes the controller gates cpu_clk_en while asleep. */
module core_model (
    input  wire logic sys_clk,      // system clock
    input  wire logic rst,          // reset, active high
    input  wire logic cpu_clk_en,   // core clock running
    output logic      instr_retire, // retire pulse
    output logic      clrwdt_exec   // clear-watchdog pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r = 8'h00;
    // firmware loop: keeps the awake watchdog from resetting the device
    always @(posedge sys_clk) begin
        cnt_r        <= rst ? 8'h00 : cnt_r + {7'h00, cpu_clk_en};
        instr_retire <= !rst && cpu_clk_en && cnt_r[1:0] == 2'h3;
        clrwdt_exec  <= !rst && cpu_clk_en && cnt_r == 8'hff;
    end
endmodule : core_model

// [tb/test_sleep_wake_control.sv]
/* Directed tests of sleep_wake_control over classic Wishbone.
   Assumes core_model as the core and a one-cycle ack from the block. */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_sleep_wake_control import sleep_wake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, cyc = 0, we = 0, sleep_exec = 0;
    logic rpin_n = 1, int_pin = 0, vhi = 0, vlo = 0, uv = 0, ot = 0;
    logic oc = 0, ov = 0, ack, clk_en, ana_on, hold, pref, core_rst;
    logic irq, asleep, retire, clrwdt, bor = 0;
    logic [7:0] pcb = 8'h00;
    logic [7:0] adr = 8'h00, dat = 8'h00, pca = 8'h00, pev = 8'h00, q;
    logic [31:0] rdat;
    int num_errors = 0, checks = 0, cyc_n = 0;
    always #10 sys_clk = ~sys_clk;
    core_model u_core (.sys_clk(sys_clk), .rst(rst), .cpu_clk_en(clk_en),
        .instr_retire(retire), .clrwdt_exec(clrwdt));
    sleep_wake_control #(.WDT_CYCLES(16), .WDT_W(24)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i({24'h000000, dat}), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt),
        .instr_retire(retire), .watchdog_enable(1'b1),
        .ext_reset_enable(1'b1), .external_reset_pin_n(rpin_n),
        .brownout_reset(bor), .ext_int_pin(int_pin), .vin_high_level(vhi),
        .vin_low_level(vlo), .out_undervolt(uv), .overtemp(ot),
        .out_overcurrent(oc), .out_overvolt(ov), .pin_change_a(pca),
        .pin_change_b(pcb), .periph_events_a(pev), .cpu_clk_en(clk_en),
        .analog_supply_on(ana_on), .port_hold(hold), .prefetch_req(pref),
        .core_reset(core_rst), .irq_req(irq), .asleep(asleep));
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    always @(posedge sys_clk) if (++cyc_n == 20000) begin
        num_errors++;
        conclude();
    end
    // held until the edge that samples ack, then released
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1; we <= w; adr <= a; dat <= d;
        // no cycle count assumed; the global timeout ends a lost ack
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask : rd
    task automatic slp();
        @(posedge sys_clk) sleep_exec <= 1;
        @(posedge sys_clk) sleep_exec <= 0;
        #1;
    endtask : slp
    task automatic wake_wait(input int lim);
        for (int n = 0; n < lim && asleep !== 1'b0; n++) @(posedge sys_clk) #1;
        `CHK(asleep, 1'b0)
        `CHK(core_rst, 1'b0)
    endtask : wake_wait
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        rd(ADR_OPTION, RST_OPTION); rd(ADR_STATUS, RST_STATUS);
        rd(8'h3c, 8'h00);
        $display("end reset_values");
        {uv, ot, oc, ov} <= 4'hf; repeat (6) @(posedge sys_clk);
        rd(ADR_FAULT, 8'hf0);
        wr(ADR_FAULT, 8'hff); {uv, ot, oc, ov} <= 4'h0;
        repeat (6) @(posedge sys_clk);
        rd(ADR_FAULT, 8'hf0);
        wr(ADR_FAULT, 8'h00); wr(ADR_LOCKOUT_CFG, 8'h05);
        {vhi, vlo} <= 2'h3; repeat (6) @(posedge sys_clk);
        rd(ADR_FAULT, 8'h03);
        wr(ADR_FAULT, 8'h00); wr(ADR_LOCKOUT_CFG, 8'h0a);
        {vhi, vlo} <= 2'h0; repeat (6) @(posedge sys_clk);
        rd(ADR_FAULT, 8'h03);
        wr(ADR_FAULT, 8'h00); wr(ADR_LOCKOUT_CFG, 8'h10);
        $display("end fault_flags");
        wr(ADR_IRQ_CONTROL, 8'h10); int_pin <= 1;
        repeat (6) @(posedge sys_clk);
        slp(); `CHK(asleep, 1'b0)
        rd(ADR_STATUS, 8'h18);
        int_pin <= 0; repeat (6) @(posedge sys_clk);
        wr(ADR_IRQ_CONTROL, 8'h10);
        slp(); `CHK({pref, asleep, hold}, 3'h7)
        `CHK({clk_en, ana_on}, 2'h0)
        rd(ADR_STATUS, 8'h10);
        int_pin <= 1; wake_wait(20);
        wr(ADR_IRQ_CONTROL, 8'h00); int_pin <= 0;
        $display("end int_wake");
        wr(ADR_PIE_A, 8'h01); wr(ADR_IOC_A, 8'h01); wr(ADR_IRQ_CONTROL, 8'h88);
        slp(); pev <= 8'h01; @(posedge sys_clk) pev <= 8'h00;
        repeat (8) @(posedge sys_clk);
        `CHK(asleep, 1'b1)
        pca <= 8'h01; wake_wait(20);
        `CHK(irq, 1'b0)
        repeat (12) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wr(ADR_IRQ_CONTROL, 8'h80); repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        wr(ADR_IRQ_CONTROL, 8'hc0); repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wr(ADR_IRQ_CONTROL, 8'h00); wr(ADR_PIR_A, 8'h00);
        $display("end ioc_wake");
        wr(ADR_LOCKOUT_CFG, 8'h20);
        slp(); wake_wait(3000);
        rd(ADR_STATUS, 8'h00);
        $display("end watchdog_wake");
        slp(); rpin_n <= 0;
        for (int n = 0; n < 20 && core_rst !== 1'b1; n++) @(posedge sys_clk);
        `CHK(core_rst, 1'b1)
        rpin_n <= 1; repeat (6) @(posedge sys_clk);
        `CHK(asleep, 1'b0)
        $display("end pin_reset");
        wr(ADR_IOC_B, 8'h80); wr(ADR_IRQ_CONTROL, 8'h08);
        slp(); bor <= 1'b1; repeat (8) @(posedge sys_clk);
        `CHK(asleep, 1'b1)
        pcb <= 8'h80; wake_wait(20);
        repeat (4) @(posedge sys_clk);
        `CHK(core_rst, 1'b1)
        bor <= 1'b0; repeat (8) @(posedge sys_clk);
        rd(ADR_STATUS, RST_STATUS);
        $display("end brownout");
        conclude();
    end
endmodule : test_sleep_wake_control
